// *** core/sbt_tap.sv ***
// boundary-scan test access port of a burst sram, with apb status
// assumes tck from the board tester, pclk from the system, and
// presetn as power-up reset for both domains
//
// Summary of operation
// (R1) instruction 1 shifts the 32-bit identification word
// (R2) id word: revision, part, maker, bit0 one
// (R3) code 000 captures pins, selects boundary register
// (R4) code 010 captures, shifts, floats memory outputs
// (R5) tester never loads codes 011, 101, 110
// (R6) code 100 captures pins into 109-bit register
// (R7) code 111 puts one-bit bypass in path
// (R8) tdi sampled rising, tdo changes falling
// (R9) capture-ir loads 01 into low bits
// (R10) reset or five tms highs load idcode
// (R11) cell 108 enables outputs under extest
// (R12) standard sixteen-state controller stepped by tms
`timescale 1ns/100ps

module sbt_tap
   import sbt_pkg::*;
#(
   // arbitrary identity values, not those of any real part
   parameter logic [2:0]  ID_REV   = 3'h2,
   parameter logic [16:0] ID_PART  = 17'h0a5a5,
   parameter logic [10:0] ID_MAKER = 11'h05a
) (
   // system clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`SBT_ADDR_W-1:0]    paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // test link
   input  wire logic                      tck,
   input  wire logic                      tms,
   input  wire logic                      tdi,
   output logic                           tdo,
   output logic                           tdo_oe_n,
   // pin ring
   input  wire logic [`SBT_RING_W-1:0]    ring_i,
   output logic      [`SBT_BSR_W-1:0]     bsr_drive_o,
   output logic                           mem_q_oe_n
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   sbt_state_t                  state_q;
   sbt_state_t                  state_d;
   logic [`SBT_IR_W-1:0]        ir_sh_q;
   logic [`SBT_IR_W-1:0]        ir_q;
   logic                        bypass_q;
   logic [`SBT_ID_W-1:0]        id_sh_q;
   logic [`SBT_BSR_W-1:0]       bsr_sh_q;
   logic [`SBT_BSR_W-1:0]       bsr_upd_q;
   logic [`SBT_RING_W-1:0]      ring_s;
   logic [`SBT_ID_W-1:0]        id_word;
   logic                        sel_bsr;
   logic                        sel_id;
   logic                        dr_out;
   sbt_mode_t                   mode_tq;
   sbt_mode_t                   mode_d;
   sbt_mode_t                   mode_p;
   logic [`SBT_STAT_W-1:0]      mode_p_v;
   logic                        ctrl_drive_q;
   logic                        hit_ctrl;
   logic                        hit_stat;
   logic                        setup;
   logic                        access;

   // ****************************************************************
   // tck domain: pin ring synchroniser
   // ****************************************************************
   // pins are asynchronous to tck, two flops before capture
   sbt_sync #(
      .W     (`SBT_RING_W)
   ) u_ring_sync (
      .clk   (tck),
      .rst_n (presetn),
      .d     (ring_i),
      .q     (ring_s)
   );

   // identification word layout
   assign id_word = {ID_REV, ID_PART, ID_MAKER, `SBT_ID_MARK}; // R2

   // ****************************************************************
   // tck domain: controller state machine
   // ****************************************************************
   // next state from tms
   always_comb begin
      state_d = state_q;
      case (state_q) // R12
         ST_TLR:    state_d = tms ? ST_TLR    : ST_RTI;
         ST_RTI:    state_d = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  state_d = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = tms ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR:  state_d = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: state_d = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_d = tms ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  state_d = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = tms ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR:  state_d = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: state_d = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_RTI;
         default:   state_d = ST_TLR;
      endcase
   end

   // state register, tms sampled on rising tck
   always_ff @(posedge tck or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_TLR;
      end else begin
         state_q <= state_d; // R8 R12
      end
   end

   // ****************************************************************
   // tck domain: instruction register
   // ****************************************************************
   // shift stage: capture 01 pattern, shift lsb first
   always_ff @(posedge tck or negedge presetn) begin
      if (!presetn) begin
         ir_sh_q <= `SBT_IR_IDCODE;
      end else if (state_q == ST_CAP_IR) begin
         ir_sh_q <= {1'b0, `SBT_IR_CAPTURE}; // R9
      end else if (state_q == ST_SH_IR) begin
         ir_sh_q <= {tdi, ir_sh_q[`SBT_IR_W-1:1]};
      end
   end

   // current instruction, idcode after reset
   always_ff @(posedge tck or negedge presetn) begin
      if (!presetn) begin
         ir_q <= `SBT_IR_IDCODE; // R10
      end else if (state_q == ST_TLR) begin
         ir_q <= `SBT_IR_IDCODE; // R10
      end else if (state_q == ST_UPD_IR) begin
         ir_q <= ir_sh_q;
      end
   end

   // data register selection, unused codes fall to bypass
   always_comb begin
      sel_bsr = 1'b0;
      sel_id  = 1'b0;
      case (ir_q)
         `SBT_IR_EXTEST:  sel_bsr = 1'b1; // R3
         `SBT_IR_SAMPLEZ: sel_bsr = 1'b1; // R4
         `SBT_IR_SAMPLE:  sel_bsr = 1'b1; // R6
         `SBT_IR_IDCODE:  sel_id  = 1'b1; // R1
         default:         sel_bsr = 1'b0; // R5 R7
      endcase
   end

   // ****************************************************************
   // tck domain: data registers
   // ****************************************************************
   // bypass cell, cleared on capture
   always_ff @(posedge tck or negedge presetn) begin
      if (!presetn) begin
         bypass_q <= 1'b0;
      end else if (state_q == ST_CAP_DR) begin
         bypass_q <= 1'b0;
      end else if (state_q == ST_SH_DR) begin
         bypass_q <= tdi; // R7
      end
   end

   // identification shift register
   always_ff @(posedge tck or negedge presetn) begin
      if (!presetn) begin
         id_sh_q <= '0;
      end else if (state_q == ST_CAP_DR && sel_id) begin
         id_sh_q <= id_word; // R1
      end else if (state_q == ST_SH_DR && sel_id) begin
         id_sh_q <= {tdi, id_sh_q[`SBT_ID_W-1:1]}; // R1
      end
   end

   // boundary shift register, msb nearest tdi
   always_ff @(posedge tck or negedge presetn) begin
      if (!presetn) begin
         bsr_sh_q <= '0;
      end else if (state_q == ST_CAP_DR && sel_bsr) begin
         // pins captured, output-enable cell keeps its latch
         bsr_sh_q <= {bsr_upd_q[`SBT_OE_CELL], ring_s}; // R3 R4 R6
      end else if (state_q == ST_SH_DR && sel_bsr) begin
         bsr_sh_q <= {tdi, bsr_sh_q[`SBT_BSR_W-1:1]}; // R6
      end
   end

   // update latch, drives pins under extest
   always_ff @(posedge tck or negedge presetn) begin
      if (!presetn) begin
         bsr_upd_q <= '0;
      end else if (state_q == ST_TLR) begin
         bsr_upd_q[`SBT_OE_CELL] <= `SBT_OE_CELL_RST;
      end else if (state_q == ST_UPD_DR && sel_bsr) begin
         bsr_upd_q <= bsr_sh_q; // R11
      end
   end

   assign bsr_drive_o = bsr_upd_q;

   // ****************************************************************
   // tck domain: serial output on falling edge
   // ****************************************************************
   // tail bit of the selected register
   always_comb begin
      if (sel_id) begin
         dr_out = id_sh_q[0];
      end else if (sel_bsr) begin
         dr_out = bsr_sh_q[0];
      end else begin
         dr_out = bypass_q;
      end
   end

   // tdo and its enable change only on falling tck
   always_ff @(negedge tck or negedge presetn) begin
      if (!presetn) begin
         tdo      <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else begin
         tdo      <= (state_q == ST_SH_IR) ? ir_sh_q[0] : dr_out; // R8
         tdo_oe_n <= !(state_q == ST_SH_IR || state_q == ST_SH_DR);
      end
   end

   // ****************************************************************
   // tck domain: mode flags for the bus side
   // ****************************************************************
   // decode to independent levels before crossing
   always_comb begin
      mode_d.id_sel  = (ir_q == `SBT_IR_IDCODE);
      mode_d.oe_cell = bsr_upd_q[`SBT_OE_CELL];
      mode_d.extest  = (ir_q == `SBT_IR_EXTEST);
      mode_d.highz   = (ir_q == `SBT_IR_SAMPLEZ);
   end

   // registered so the crossing sees no decode glitch; falling tck
   // so the last rise of a frame is taken before tck stands still
   always_ff @(negedge tck or negedge presetn) begin
      if (!presetn) begin
         mode_tq <= '0;
      end else begin
         mode_tq <= mode_d;
      end
   end

   // ****************************************************************
   // pclk domain: crossing and memory output enable
   // ****************************************************************
   sbt_sync #(
      .W     (`SBT_STAT_W)
   ) u_mode_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (mode_tq),
      .q     (mode_p_v)
   );

   assign mode_p = sbt_mode_t'(mode_p_v);

   // output drivers: extest cell, sample-z float, else core drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_q_oe_n <= 1'b1;
      end else if (mode_p.extest) begin
         mem_q_oe_n <= !mode_p.oe_cell; // R11
      end else if (mode_p.highz) begin
         mem_q_oe_n <= 1'b1; // R4
      end else begin
         mem_q_oe_n <= !ctrl_drive_q;
      end
   end

   // ****************************************************************
   // pclk domain: apb slave
   // ****************************************************************
   assign setup    = psel && !penable;
   assign access   = psel && penable;
   assign hit_ctrl = (paddr == `SBT_ADDR_CTRL);
   assign hit_stat = (paddr == `SBT_ADDR_STAT);
   assign pready   = 1'b1;
   assign pslverr  = access && !(hit_ctrl || hit_stat);

   // control register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_drive_q <= `SBT_CTRL_RST;
      end else if (access && pwrite && hit_ctrl) begin
         ctrl_drive_q <= pwdata[`SBT_CTRL_DRIVE];
      end
   end

   // read data prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup && !pwrite && hit_ctrl) begin
         prdata <= {31'h0, ctrl_drive_q};
      end else if (setup && !pwrite && hit_stat) begin
         prdata <= {28'h0, mode_p_v};
      end else if (setup) begin
         prdata <= '0;
      end
   end

   // ****************************************************************
   // assertions, tck domain
   // ****************************************************************
   AST_ID_CAPTURE: assert property (@(posedge tck) disable iff (!presetn)
      (state_q == ST_CAP_DR && ir_q == `SBT_IR_IDCODE)
      |=> (id_sh_q == id_word && id_sh_q[0] == 1'b1)) // R1 R2
      else $error("id word not captured");

   AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (!presetn)
      state_q == ST_CAP_IR |=> ir_sh_q[1:0] == 2'h1) // R9
      else $error("capture-ir pattern wrong");

   AST_TLR_IDCODE: assert property (@(posedge tck) disable iff (!presetn)
      state_q == ST_TLR |=> ir_q == `SBT_IR_IDCODE) // R10
      else $error("reset did not load idcode");

   AST_TMS_FIVE: assert property (@(posedge tck) disable iff (!presetn)
      tms [*5] |=> state_q == ST_TLR) // R10 R12
      else $error("five tms highs did not reset");

   AST_UPD_IR: assert property (@(posedge tck) disable iff (!presetn)
      state_q == ST_UPD_IR |=> ir_q == $past(ir_sh_q)) // R12
      else $error("update-ir did not load instruction");

   AST_BSR_CAPTURE: assert property (@(posedge tck) disable iff (!presetn)
      (state_q == ST_CAP_DR && (ir_q == `SBT_IR_EXTEST
                             || ir_q == `SBT_IR_SAMPLE
                             || ir_q == `SBT_IR_SAMPLEZ))
      |=> bsr_sh_q[`SBT_RING_W-1:0] == $past(ring_s)) // R3 R4 R6
      else $error("pin ring not captured");

   AST_BYPASS: assert property (@(posedge tck) disable iff (!presetn)
      (state_q == ST_SH_DR && ir_q == `SBT_IR_BYPASS)
      |-> (tdo == bypass_q && !tdo_oe_n)) // R7 R8
      else $error("bypass path not on tdo");

   AST_TDO_IDLE: assert property (@(posedge tck) disable iff (!presetn)
      (state_q == ST_RTI) [*2] |-> tdo_oe_n) // R8
      else $error("tdo driven outside shift");

   // ****************************************************************
   // assertions, pclk domain
   // ****************************************************************
   AST_HIGHZ: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_p.highz && !mode_p.extest) |=> mem_q_oe_n) // R4
      else $error("outputs driven under sample-z");

   AST_EXTEST_OE: assert property (@(posedge pclk) disable iff (!presetn)
      mode_p.extest |=> mem_q_oe_n == !$past(mode_p_v[2])) // R11
      else $error("extest output cell ignored");

   // ****************************************************************
   // covers
   // ****************************************************************
   COV_ID_SHIFT: cover property (@(posedge tck) disable iff (!presetn)
      state_q == ST_SH_DR && sel_id);
   COV_EXTEST_UPD: cover property (@(posedge tck) disable iff (!presetn)
      state_q == ST_UPD_DR && ir_q == `SBT_IR_EXTEST);
   COV_SAMPLEZ: cover property (@(posedge pclk) disable iff (!presetn)
      mode_p.highz ##1 mem_q_oe_n);
   COV_BYPASS: cover property (@(posedge tck) disable iff (!presetn)
      state_q == ST_SH_DR && ir_q == `SBT_IR_BYPASS);

endmodule : sbt_tap

// *** core/sbt_map.svh ***
// constants of the sram boundary-scan test port
// assumes inclusion by bare name from the package and the top module
`ifndef SBT_MAP_SVH
`define SBT_MAP_SVH

// ****************************************************************
// scan register sizes
// ****************************************************************
`define SBT_IR_W        3
`define SBT_ID_W        32
`define SBT_BSR_W       109
`define SBT_RING_W      108
`define SBT_OE_CELL     108

// ****************************************************************
// instruction codes
// ****************************************************************
`define SBT_IR_EXTEST   3'h0
`define SBT_IR_IDCODE   3'h1
`define SBT_IR_SAMPLEZ  3'h2
`define SBT_IR_SAMPLE   3'h4
`define SBT_IR_BYPASS   3'h7
`define SBT_IR_CAPTURE  2'h1
`define SBT_OE_CELL_RST 1'b0

// ****************************************************************
// identification word fields
// ****************************************************************
`define SBT_ID_REV_W    3
`define SBT_ID_PART_W   17
`define SBT_ID_MAKER_W  11
`define SBT_ID_MARK     1'b1

// ****************************************************************
// apb register map
// ****************************************************************
`define SBT_ADDR_W      12
`define SBT_ADDR_CTRL   12'h000
`define SBT_ADDR_STAT   12'h004
`define SBT_CTRL_DRIVE  0
`define SBT_CTRL_RST    1'b1
`define SBT_STAT_W      4
`define SBT_TLR_EDGES   5

`endif

// *** core/sbt_pkg.sv ***
// types of the sram boundary-scan test port
// assumes sbt_map.svh is on the include path
`include "sbt_map.svh"

package sbt_pkg;

   // tap controller states
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
      ST_PA_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
      ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } sbt_state_t;

   // decoded instruction flags and the output-enable cell that cross to the bus clock
   typedef struct packed {
      logic id_sel;
      logic oe_cell;
      logic extest;
      logic highz;
   } sbt_mode_t;

endpackage : sbt_pkg

// *** core/sbt_sync.sv ***
// two-flop level synchroniser, width set by parameter
// assumes each bit is an independent level
`timescale 1ns/100ps

module sbt_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : sbt_sync

// *** test/sbt_tester.sv ***
// board tester model driving the test link of the boundary-scan port
// assumes the bench calls its tasks one at a time from a single process
`timescale 1ns/100ps

module sbt_tester (
   // test link
   output logic     tck,
   output logic     tms,
   output logic     tdi,
   input wire logic tdo
);

   // ****************************************************************
   // link stepping
   // ****************************************************************

   // tck stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one tck period, 6 ns; tdo taken at the rising edge
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #3 tck = 1'b1;
      o = tdo;
      #3 tck = 1'b0;
   endtask : step

   // five tms highs force test-logic-reset
   task automatic tlr();
      logic o;
      repeat (5) step(1'b1, ~tdi, o);
   endtask : tlr

   // full ir or dr scan from and back to run-test-idle
   task automatic scan(input logic ir, input int n,
                       input logic [108:0] din, output logic [108:0] dout);
      logic o;
      if (ir && din[2:0] inside {3'h3, 3'h5, 3'h6}) din[2:0] = 3'h7;
      dout = '0;
      step(1'b0, ~tdi, o);
      step(1'b1, ~tdi, o);
      if (ir) step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
      step(1'b0, ~tdi, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
   endtask : scan

endmodule : sbt_tester

// *** test/sram_boundary_scan_tap_bench.sv ***
// self-checking bench of the boundary-scan port with apb status
// assumes sbt_map.svh on the include path and sbt_tester as partner
`timescale 1ns/100ps
`include "sbt_map.svh"

module sram_boundary_scan_tap_bench;

   // arbitrary identity values
   localparam logic [2:0]  REV   = 3'h5;
   localparam logic [16:0] PART  = 17'h13579;
   localparam logic [10:0] MAKER = 11'h2c3;
   localparam logic [31:0] ID    = {REV, PART, MAKER, 1'b1};
   localparam logic [11:0] CTRL  = `SBT_ADDR_CTRL;
   localparam logic [11:0] STAT  = `SBT_ADDR_STAT;

   logic          pclk, presetn, psel, penable, pwrite;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic          pready, pslverr, er;
   logic          tck, tms, tdi, tdo, tdo_oe_n, mem_q_oe_n;
   logic          tdo_line;
   logic [107:0]  ring_i;
   logic [108:0]  bsr_drive_o, so;
   int            mismatches, checked;

   // ****************************************************************
   // instances and clock
   // ****************************************************************
   sbt_tap #(.ID_REV(REV), .ID_PART(PART), .ID_MAKER(MAKER)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .ring_i(ring_i),
      .bsr_drive_o(bsr_drive_o), .mem_q_oe_n(mem_q_oe_n));

   // a released tdo shows the inverse, so a late enable is caught
   assign tdo_line = tdo_oe_n ? !tdo : tdo;

   sbt_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [108:0] got, input logic [108:0] exp,
                      input string m);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk

   // one apb transfer; read data and error land in rd and er
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // mode flags cross from tck to pclk
   task automatic settle();
      repeat (12) @(posedge pclk);
   endtask : settle

   task automatic status(input logic [3:0] exp, input string m);
      settle();
      apb(1'b0, STAT, 32'h0);
      chk(rd[3:0], exp, m);
   endtask : status

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_id();
      i_tester.scan(1'b0, 32, '0, so);
      chk(so[31:0], ID, "id word after reset");
      chk(tdo_oe_n, 1'b1, "tdo enabled outside shift");
      chk(mem_q_oe_n, 1'b0, "memory drive under idcode");
      status(4'h8, "status idcode");
   endtask : t_id

   task automatic t_bypass();
      i_tester.scan(1'b1, 3, 109'h7, so);
      chk(so[1:0], 2'b01, "ir capture pattern");
      i_tester.scan(1'b0, 4, 109'hb, so);
      chk(so[3:0], 4'h6, "bypass path");
      chk(mem_q_oe_n, 1'b0, "memory drive under bypass");
   endtask : t_bypass

   task automatic t_sample();
      i_tester.scan(1'b1, 3, 109'h4, so);
      i_tester.scan(1'b0, 109, {1'b1, ~ring_i}, so);
      chk(so, {1'b0, ring_i}, "sample capture");
      status(4'h4, "status after preload");
      chk(bsr_drive_o, {1'b1, ~ring_i}, "preload latch");
      chk(mem_q_oe_n, 1'b0, "memory drive under sample");
   endtask : t_sample

   task automatic t_extest();
      i_tester.scan(1'b1, 3, 109'h0, so);
      status(4'h6, "status extest");
      chk(mem_q_oe_n, 1'b0, "cell high drives");
      i_tester.scan(1'b0, 109, {1'b0, ring_i}, so);
      chk(so, {1'b1, ring_i}, "extest capture");
      settle();
      chk(mem_q_oe_n, 1'b1, "cell low floats");
   endtask : t_extest

   task automatic t_samplez();
      i_tester.scan(1'b1, 3, 109'h2, so);
      status(4'h1, "status sample-z");
      chk(mem_q_oe_n, 1'b1, "outputs floated");
      i_tester.scan(1'b0, 109, '0, so);
      chk(so[107:0], ring_i, "sample-z capture");
      i_tester.scan(1'b1, 3, 109'h1, so);
      status(4'h8, "status idcode again");
      chk(mem_q_oe_n, 1'b0, "drive restored");
   endtask : t_samplez

   task automatic t_apb();
      apb(1'b0, CTRL, 32'h0);
      chk(rd, 32'h1, "ctrl reset value");
      apb(1'b1, CTRL, 32'h0);
      settle();
      chk(mem_q_oe_n, 1'b1, "core drive off");
      apb(1'b1, STAT, 32'hf);
      apb(1'b0, STAT, 32'h0);
      chk(rd, 32'h8, "status read only");
      apb(1'b0, 12'h008, 32'h0);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped address");
      apb(1'b1, CTRL, 32'h1);
      settle();
      chk(mem_q_oe_n, 1'b0, "core drive on");
   endtask : t_apb

   task automatic t_tlr();
      i_tester.scan(1'b1, 3, 109'h0, so);
      i_tester.tlr();
      status(4'h8, "tms reset loads idcode");
      i_tester.scan(1'b0, 32, '0, so);
      chk(so[31:0], ID, "id word after tms reset");
   endtask : t_tlr

   // ****************************************************************
   // run control
   // ****************************************************************
   task automatic wrap_up();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // scans take a few microseconds; well past that means a hang
   initial begin
      #50000;
      mismatches++;
      wrap_up();
   end

   // reset, then the scenarios in turn
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      ring_i = 108'h123456789abcdef0fedcba98765;
      mismatches = 0;
      checked = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_id();
      t_bypass();
      t_sample();
      t_extest();
      t_samplez();
      t_apb();
      t_tlr();
      wrap_up();
   end

endmodule : sram_boundary_scan_tap_bench
